// File: logic/lhsr_limp_home_stop_recovery.sv
`timescale 1ns/1ps
module lhsr_limp_home_stop_recovery
	import lhsr_pkg::*;
#(
	parameter int CNT_BITS = LHSR_CNT_BITS
) (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic xclkTick,
	input wire logic pllSupplyPresent,
	input wire logic normalMode,
	input wire logic extClkPresent,
	input wire logic cfgWrite,
	input wire logic cfgClkMonitorEn,
	input wire logic cfgForcedClkMonitorEn,
	input wire logic cfgPllPowerOn,
	input wire logic cfgFallbackDisable,
	input wire logic wakeDelayEn,
	input wire logic oscKeepStopEn,
	input wire logic fallbackIrqEn,
	input wire logic fallbackIrqClr,
	input wire logic busClkSelSynth,
	input wire logic moduleClkSel,
	input wire logic stopExec,
	input wire logic extResetWake,
	input wire logic irqWake,
	input wire logic nonmaskableIrqPin,
	input wire logic keyWakeJ,
	input wire logic keyWakeH,
	input wire logic canWake,
	output logic intReset_reg,
	output logic stopActive_reg,
	output logic oscEnable_reg,
	output logic useVcoClk_reg,
	output logic fallbackActiveFlag_reg,
	output logic fallbackIrqFlag_reg,
	output logic irqRequest_reg,
	output logic clkMonResetReq_reg,
	output logic busClkSelOut_reg,
	output logic moduleClkSelOut_reg,
	output logic clkMonitorEn_reg,
	output logic forcedClkMonitorEn_reg,
	output logic pllPowerOn_reg,
	output logic fallbackDisable_reg,
	output logic monitorActive_reg
);
	//------------------------------------------------------------
	// Elaboration check, internal signals and decode.
	//------------------------------------------------------------
	// The mid-count compare needs at least two counter bits.
	if (CNT_BITS < 2) begin : gBadWidth
		$error("CNT_BITS must be at least 2.");
	end
	localparam logic [CNT_BITS-1:0] MID_LAST =
		CNT_BITS'((1 << (CNT_BITS - 1)) - 1);
	lhsr_state_t state_reg; // Sequencer state.
	lhsr_state_t stateNext; // Next sequencer state.
	logic [CNT_BITS-1:0] cnt_reg; // Free-running counter.
	logic extSeen_reg; // External clock seen in this reset period.
	logic noLimpLatch_reg; // Blocks fallback after a monitor reset.
	logic pseudo_reg; // The current STOP keeps the oscillator.
	logic useVcoNext; // Next fallback clock selection.
	logic flagNext; // Next fallback status flag.
	logic irqFlagNext; // Next interrupt flag.
	logic extSeenNext; // Next external-clock-seen mark.
	logic clkMonRstNext; // Monitor reset requested this cycle.
	logic [5:0] wakeVec; // All wake sources side by side.
	logic wakeAny; // Any wake source active.
	logic limpAllowed; // Fallback may be used now.
	logic monEnabled; // Either monitor enable bit is set.
	logic resetLimpOk; // Fallback may be used during reset.
	logic cntTick; // Counter advances this cycle.
	logic midHit; // Counter reaches the mid-count this cycle.
	// Any one source ends STOP or pseudo-STOP.
	assign wakeVec = {extResetWake, irqWake, nonmaskableIrqPin,
		keyWakeJ, keyWakeH, canWake};
	assign wakeAny = |wakeVec;
	assign limpAllowed = pllSupplyPresent && !fallbackDisable_reg;
	assign monEnabled = clkMonitorEn_reg || forcedClkMonitorEn_reg;
	// Power-up fallback needs the supply, a normal mode and no latch.
	assign resetLimpOk = pllSupplyPresent && normalMode &&
		!noLimpLatch_reg;
	// The counter only moves while some clock really runs, so with no
	// supply and no crystal the block sits still.
	assign cntTick = xclkTick && (state_reg != LHSR_ST_STOP) &&
		(useVcoClk_reg || extClkPresent);
	assign midHit = cntTick && (cnt_reg == MID_LAST);
	//------------------------------------------------------------
	// Sequencer decision, state and fallback flags.
	//------------------------------------------------------------
	// All fallback entries and exits are decided here.
	always_comb begin
		stateNext = state_reg;
		useVcoNext = useVcoClk_reg;
		flagNext = fallbackActiveFlag_reg;
		extSeenNext = extSeen_reg;
		clkMonRstNext = 1'b0;
		case (state_reg)
			LHSR_ST_RESET: begin
				// A detected crystal takes over the counter at once.
				if (extClkPresent) begin
					useVcoNext = 1'b0;
					extSeenNext = 1'b1;
				end else if (!extSeen_reg && resetLimpOk) begin
					useVcoNext = 1'b1;
				end
				if (midHit) begin
					stateNext = LHSR_ST_RUN;
					extSeenNext = 1'b0;
					// Fallback with no crystal stays and is flagged.
					flagNext = useVcoClk_reg && !extClkPresent;
					useVcoNext = flagNext;
				end
			end
			LHSR_ST_RUN: begin
				if (stopExec && !limpAllowed && monEnabled) begin
					// STOP would look like a lost clock: reset instead.
					clkMonRstNext = 1'b1;
					stateNext = LHSR_ST_RESET;
					useVcoNext = 1'b0;
					flagNext = 1'b0;
				end else if (stopExec) begin
					stateNext = LHSR_ST_STOP;
				end else if (fallbackActiveFlag_reg && midHit &&
					extClkPresent) begin
					useVcoNext = 1'b0;
					flagNext = 1'b0;
				end
			end
			LHSR_ST_STOP: begin
				if (wakeAny && limpAllowed) begin
					if (wakeDelayEn) begin
						stateNext = LHSR_ST_WAKE;
						useVcoNext = 1'b1;
					end else begin
						// No delay: a live clock is used at once; with none, fallback is flagged.
						stateNext = LHSR_ST_RUN;
						useVcoNext = !extClkPresent;
						flagNext = !extClkPresent;
					end
				end else if (wakeAny) begin
					// Without fallback only the crystal can restart us.
					stateNext = wakeDelayEn ? LHSR_ST_WAKE :
						LHSR_ST_RUN;
					useVcoNext = 1'b0;
					flagNext = 1'b0;
				end
			end
			LHSR_ST_WAKE: begin
				if (midHit) begin
					stateNext = LHSR_ST_RUN;
					if (useVcoClk_reg) begin
						useVcoNext = !extClkPresent;
						flagNext = !extClkPresent;
					end
				end
			end
			default: begin
				stateNext = LHSR_ST_RESET;
			end
		endcase
		// A flag change raises the interrupt flag; set beats clear.
		irqFlagNext = (flagNext != fallbackActiveFlag_reg) ||
			(fallbackIrqFlag_reg && !fallbackIrqClr);
	end
	// State, fallback clock and status flags move together.
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			state_reg <= LHSR_ST_RESET;
			useVcoClk_reg <= 1'b0;
			fallbackActiveFlag_reg <= 1'b0;
			fallbackIrqFlag_reg <= 1'b0;
			irqRequest_reg <= 1'b0;
			extSeen_reg <= 1'b0;
			clkMonResetReq_reg <= 1'b0;
		end else begin
			state_reg <= stateNext;
			useVcoClk_reg <= useVcoNext;
			fallbackActiveFlag_reg <= flagNext;
			fallbackIrqFlag_reg <= irqFlagNext;
			irqRequest_reg <= irqFlagNext && fallbackIrqEn;
			extSeen_reg <= extSeenNext;
			clkMonResetReq_reg <= clkMonRstNext;
		end
	end
	// The latch keeps a monitor reset from leaving reset in fallback,
	// since that reset clears the disable bit itself.
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			noLimpLatch_reg <= 1'b0;
		end else if (clkMonRstNext) begin
			noLimpLatch_reg <= 1'b1;
		end else if (state_reg == LHSR_ST_RESET && midHit) begin
			noLimpLatch_reg <= 1'b0;
		end
	end
	//------------------------------------------------------------
	// Counter, control bits and keep-oscillator choice.
	//------------------------------------------------------------
	// Cleared at reset end, during STOP and at wake end, so the first
	// poll comes 4096 counts later and then once per wrap.
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			cnt_reg <= '0;
		end else if (state_reg == LHSR_ST_STOP) begin
			cnt_reg <= '0;
		end else if (midHit && state_reg != LHSR_ST_RUN) begin
			cnt_reg <= '0;
		end else if (cntTick) begin
			cnt_reg <= cnt_reg + 1'b1;
		end
	end
	// Every reset period restores the monitor, PLL and disable bits while the supply is there; the forced monitor bit keeps its value.
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			clkMonitorEn_reg <= LHSR_MON_EN_RST;
			forcedClkMonitorEn_reg <= LHSR_FMON_EN_RST;
			pllPowerOn_reg <= LHSR_PLL_ON_RST;
			fallbackDisable_reg <= LHSR_FB_DIS_RST;
		end else if (state_reg == LHSR_ST_RESET) begin
			clkMonitorEn_reg <= pllSupplyPresent;
			pllPowerOn_reg <= pllSupplyPresent;
			fallbackDisable_reg <= 1'b0;
		end else if (cfgWrite) begin
			clkMonitorEn_reg <= cfgClkMonitorEn;
			forcedClkMonitorEn_reg <= cfgForcedClkMonitorEn;
			pllPowerOn_reg <= cfgPllPowerOn && pllSupplyPresent;
			fallbackDisable_reg <= cfgFallbackDisable;
		end
	end
	// The keep-oscillator choice is taken when STOP is entered.
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			pseudo_reg <= 1'b0;
		end else if (state_reg == LHSR_ST_RUN && stopExec) begin
			pseudo_reg <= oscKeepStopEn;
		end
	end
	//------------------------------------------------------------
	// Clock tree controls and phase outputs.
	//------------------------------------------------------------
	// Selects follow software outside fallback, so software may clear
	// the PLL select during fallback to keep the PLL unused later.
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			busClkSelOut_reg <= LHSR_BUS_SEL_RST;
			moduleClkSelOut_reg <= LHSR_MOD_SEL_RST;
			monitorActive_reg <= LHSR_MON_EN_RST;
			intReset_reg <= 1'b1;
			stopActive_reg <= 1'b0;
			oscEnable_reg <= 1'b1;
		end else begin
			busClkSelOut_reg <= useVcoNext || busClkSelSynth;
			moduleClkSelOut_reg <= !useVcoNext && moduleClkSel;
			// Fallback forces the monitor on; STOP with fallback masks it.
			monitorActive_reg <= useVcoNext || (monEnabled &&
				(stateNext != LHSR_ST_STOP || !limpAllowed));
			intReset_reg <= (stateNext == LHSR_ST_RESET);
			stopActive_reg <= (stateNext == LHSR_ST_STOP) ||
				(stateNext == LHSR_ST_WAKE);
			oscEnable_reg <= (stateNext != LHSR_ST_STOP) ||
				(state_reg == LHSR_ST_RUN ? oscKeepStopEn :
				pseudo_reg);
		end
	end
	//------------------------------------------------------------
	// Assertions.
	//------------------------------------------------------------
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);
	// The request flop saw the enable one edge before the flag shows.
	flagIrq_a: assert property ($changed(fallbackActiveFlag_reg) |->
		fallbackIrqFlag_reg && (irqRequest_reg == $past(fallbackIrqEn)))
		else $error("Flag change did not raise the interrupt flag.");
	resetEnd_a: assert property ($fell(intReset_reg) |->
		$past(cnt_reg) == MID_LAST && cnt_reg == '0)
		else $error("Internal reset ended off the mid-count.");
	resetLimp_a: assert property (state_reg == LHSR_ST_RESET && midHit &&
		useVcoClk_reg && !extClkPresent |=> fallbackActiveFlag_reg &&
		!intReset_reg && fallbackIrqFlag_reg)
		else $error("Reset end without clock did not flag fallback.");
	stopMonRst_a: assert property (state_reg == LHSR_ST_RUN && stopExec &&
		!limpAllowed && monEnabled |=> clkMonResetReq_reg &&
		intReset_reg ##1 !clkMonResetReq_reg)
		else $error("STOP with monitor on did not reset.");
	fastWake_a: assert property (state_reg == LHSR_ST_STOP && wakeAny &&
		limpAllowed && !wakeDelayEn && !extClkPresent |=>
		!stopActive_reg && fallbackActiveFlag_reg && useVcoClk_reg)
		else $error("Fast recovery did not resume in fallback.");
	extWake_a: assert property (state_reg == LHSR_ST_STOP && wakeAny &&
		!wakeDelayEn && extClkPresent |=> !stopActive_reg &&
		!fallbackActiveFlag_reg)
		else $error("External clock wake set the fallback flag.");
	pollExit_a: assert property (state_reg == LHSR_ST_RUN && !stopExec &&
		fallbackActiveFlag_reg && midHit && extClkPresent |=>
		!fallbackActiveFlag_reg && fallbackIrqFlag_reg && !useVcoClk_reg)
		else $error("Poll with clock present did not leave fallback.");
	selForce_a: assert property (useVcoClk_reg |->
		busClkSelOut_reg && !moduleClkSelOut_reg)
		else $error("Fallback did not force the clock selects.");
	ctrlReset_a: assert property (state_reg == LHSR_ST_RESET &&
		pllSupplyPresent |=> clkMonitorEn_reg && pllPowerOn_reg &&
		!fallbackDisable_reg)
		else $error("Reset did not restore the control bits.");
	wakeDelay_a: assert property (state_reg == LHSR_ST_WAKE && midHit
		|=> !stopActive_reg)
		else $error("Wake delay did not end at the mid-count.");
	porLimpCov_c: cover property ($fell(intReset_reg) &&
		fallbackActiveFlag_reg);
	delayWakeCov_c: cover property (state_reg == LHSR_ST_WAKE && midHit);
	monRstCov_c: cover property (clkMonResetReq_reg);
	pollExitCov_c: cover property ($fell(fallbackActiveFlag_reg));
endmodule : lhsr_limp_home_stop_recovery

// File: logic/lhsr_pkg.sv
//------------------------------------------------------------
// Shared constants for the clock fallback and stop recovery.
//------------------------------------------------------------
package lhsr_pkg;

	// Width of the free-running delay and poll counter.
	localparam int LHSR_CNT_BITS = 13;
	// Count at which reset ends, wake delays end and polls fire.
	localparam int LHSR_MID_COUNT = 4096;
	// Distance between two periodic polls of the clock monitor.
	localparam int LHSR_WRAP_COUNT = 8192;

	// Reset values of the software control bits.
	localparam logic LHSR_MON_EN_RST = 1'b1;
	localparam logic LHSR_FMON_EN_RST = 1'b0;
	localparam logic LHSR_PLL_ON_RST = 1'b1;
	localparam logic LHSR_FB_DIS_RST = 1'b0;
	// Reset values of the clock selects seen by the clock tree.
	localparam logic LHSR_BUS_SEL_RST = 1'b1;
	localparam logic LHSR_MOD_SEL_RST = 1'b0;

	// Sequencer states.
	typedef enum logic [1:0] {
		LHSR_ST_RESET = 2'b00,
		LHSR_ST_RUN = 2'b01,
		LHSR_ST_STOP = 2'b10,
		LHSR_ST_WAKE = 2'b11
	} lhsr_state_t;

endpackage : lhsr_pkg

// File: tb/lhsr_osc_model.sv
`timescale 1ns/1ps

//------------------------------------------------------------
// Far side: crystal oscillator, square-wave source, clock monitor.
//------------------------------------------------------------
module lhsr_osc_model #(
	parameter int STARTUP = 3,
	parameter int DIV = 1
) (
	input wire logic clk_sys,
	input wire logic oscEnable,
	input wire logic crystalOk,
	input wire logic squareWave,
	output logic extClkPresent,
	output logic xclkTick
);
	// Cycles the crystal has been running since it was last stopped.
	int startCnt_reg = 0;
	// Slow divider position; DIV of 1 ticks on every cycle.
	int divCnt_reg = 0;

	// The crystal only counts as present after its start-up time, so
	// a wake never sees a clock the instant the oscillator restarts.
	always @(posedge clk_sys) begin
		if (oscEnable && crystalOk) begin
			if (startCnt_reg < STARTUP) begin
				startCnt_reg <= startCnt_reg + 1;
			end
		end else begin
			startCnt_reg <= 0;
		end
	end

	// Divider for the crystal-domain tick.
	always @(posedge clk_sys) begin
		divCnt_reg <= (divCnt_reg >= DIV - 1) ? 0 : divCnt_reg + 1;
	end

	// A square-wave source runs whatever the oscillator enable says.
	assign extClkPresent = squareWave || (startCnt_reg >= STARTUP);
	assign xclkTick = (divCnt_reg == DIV - 1);
endmodule : lhsr_osc_model

// File: tb/lhsr_limp_home_stop_recovery_tb.sv
`timescale 1ns/1ps

//------------------------------------------------------------
// Self-checking bench for the clock fallback and stop recovery.
//------------------------------------------------------------
module lhsr_limp_home_stop_recovery_tb
	import lhsr_pkg::*;
;
	// A short counter keeps every wait brief; mid-count is 8.
	localparam int CNT = 4;
	localparam int MID = 2 ** (CNT - 1);
	localparam int WRAP = 2 ** CNT;
	logic clk_sys, rst, xclkTick, pllSupplyPresent, normalMode;
	logic extClkPresent, cfgWrite, cfgClkMonitorEn, cfgForcedClkMonitorEn;
	logic cfgPllPowerOn, cfgFallbackDisable, wakeDelayEn, oscKeepStopEn;
	logic fallbackIrqEn, fallbackIrqClr, busClkSelSynth, moduleClkSel;
	logic stopExec, extResetWake, irqWake, nonmaskableIrqPin;
	logic keyWakeJ, keyWakeH, canWake, intReset_reg, stopActive_reg;
	logic oscEnable_reg, useVcoClk_reg, fallbackActiveFlag_reg;
	logic fallbackIrqFlag_reg, irqRequest_reg, clkMonResetReq_reg;
	logic busClkSelOut_reg, moduleClkSelOut_reg, clkMonitorEn_reg;
	logic forcedClkMonitorEn_reg, pllPowerOn_reg, fallbackDisable_reg;
	logic monitorActive_reg, crystalOk, squareWave;
	int nErrors = 0;
	int testsRun = 0;
	int cycles = 0;
	int n;

	lhsr_limp_home_stop_recovery #(.CNT_BITS(CNT)) dut_u (.clk_sys, .rst,
		.xclkTick, .pllSupplyPresent, .normalMode, .extClkPresent, .cfgWrite,
		.cfgClkMonitorEn, .cfgForcedClkMonitorEn, .cfgPllPowerOn,
		.cfgFallbackDisable, .wakeDelayEn, .oscKeepStopEn, .fallbackIrqEn,
		.fallbackIrqClr, .busClkSelSynth, .moduleClkSel, .stopExec,
		.extResetWake, .irqWake, .nonmaskableIrqPin, .keyWakeJ, .keyWakeH,
		.canWake, .intReset_reg, .stopActive_reg, .oscEnable_reg,
		.useVcoClk_reg, .fallbackActiveFlag_reg, .fallbackIrqFlag_reg,
		.irqRequest_reg, .clkMonResetReq_reg, .busClkSelOut_reg,
		.moduleClkSelOut_reg, .clkMonitorEn_reg, .forcedClkMonitorEn_reg,
		.pllPowerOn_reg, .fallbackDisable_reg, .monitorActive_reg);

	lhsr_osc_model osc_u (.clk_sys, .oscEnable(oscEnable_reg), .crystalOk,
		.squareWave, .extClkPresent, .xclkTick);

	//------------------------------------------------------------
	// Clock, closing report and hang guard.
	//------------------------------------------------------------
	always #2.5 clk_sys = ~clk_sys;

	task automatic printVerdict();
		$display("checks=%0d errors=%0d", testsRun, nErrors);
		if (nErrors == 0 && testsRun > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : printVerdict

	// The whole run needs well under a thousand cycles.
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 5000) begin
			nErrors++;
			printVerdict();
		end
	end

	//------------------------------------------------------------
	// Access tasks.
	//------------------------------------------------------------
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		testsRun++;
		if (seen !== exp) begin
			nErrors++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check

	// Samples one output each cycle until it reaches val or lim runs out.
	task automatic waitSig(input int sel, input logic val, input int lim,
		output int cnt);
		logic s;
		for (cnt = 0; cnt <= lim; cnt++) begin
			#1;
			case (sel)
				0: s = intReset_reg;
				1: s = stopActive_reg;
				2: s = useVcoClk_reg;
				default: s = clkMonResetReq_reg;
			endcase
			if (s === val) break;
			@(posedge clk_sys);
		end
		check(s, val);
	endtask : waitSig

	// Reset is held five cycles with the given supply, mode and crystal.
	task automatic doReset(input logic sup, input logic nrm, input logic ok);
		@(posedge clk_sys);
		rst <= 1'b1;
		pllSupplyPresent <= sup;
		normalMode <= nrm;
		crystalOk <= ok;
		repeat (4) @(posedge clk_sys);
		#1;
		if (sup) begin
			check({clkMonitorEn_reg, forcedClkMonitorEn_reg, pllPowerOn_reg,
				fallbackDisable_reg, busClkSelOut_reg, moduleClkSelOut_reg,
				intReset_reg}, 16'h0055);
		end
		@(posedge clk_sys);
		rst <= 1'b0;
	endtask : doReset

	task automatic cfg(input logic m, input logic f, input logic p,
		input logic d);
		@(posedge clk_sys);
		{cfgClkMonitorEn, cfgForcedClkMonitorEn} <= {m, f};
		{cfgPllPowerOn, cfgFallbackDisable, cfgWrite} <= {p, d, 1'b1};
		@(posedge clk_sys);
		cfgWrite <= 1'b0;
	endtask : cfg

	task automatic stop();
		@(posedge clk_sys);
		stopExec <= 1'b1;
		@(posedge clk_sys);
		stopExec <= 1'b0;
		#1;
	endtask : stop

	task automatic setWake(input int i, input logic v);
		case (i)
			0: extResetWake <= v;
			1: irqWake <= v;
			2: nonmaskableIrqPin <= v;
			3: keyWakeJ <= v;
			4: keyWakeH <= v;
			default: canWake <= v;
		endcase
	endtask : setWake

	//------------------------------------------------------------
	// Scenarios.
	//------------------------------------------------------------
	initial begin
		clk_sys = 0;
		rst = 1;
		{pllSupplyPresent, normalMode, busClkSelSynth} = 3'b111;
		{cfgWrite, cfgClkMonitorEn, cfgForcedClkMonitorEn} = 3'b000;
		{cfgPllPowerOn, cfgFallbackDisable, wakeDelayEn} = 3'b000;
		{oscKeepStopEn, fallbackIrqEn, fallbackIrqClr} = 3'b000;
		{moduleClkSel, stopExec, extResetWake, irqWake} = 4'b0000;
		{nonmaskableIrqPin, keyWakeJ, keyWakeH, canWake} = 4'b0000;
		{crystalOk, squareWave} = 2'b00;
		// Power-up with no clock leaves reset in fallback.
		doReset(1'b1, 1'b1, 1'b0);
		waitSig(0, 1'b0, MID + 8, n);
		check({n >= MID, n <= MID + 4}, 16'h0003);
		check({useVcoClk_reg, fallbackActiveFlag_reg, fallbackIrqFlag_reg,
			busClkSelOut_reg, moduleClkSelOut_reg}, 16'h001E);
		@(posedge clk_sys);
		fallbackIrqEn <= 1'b1;
		busClkSelSynth <= 1'b0;
		moduleClkSel <= 1'b1;
		repeat (2) @(posedge clk_sys);
		#1;
		check({irqRequest_reg, busClkSelOut_reg, moduleClkSelOut_reg},
			16'h0006);
		crystalOk <= 1'b1;
		waitSig(2, 1'b0, 2 * WRAP + 8, n);
		check(n <= MID + 2, 1);
		check({fallbackActiveFlag_reg, fallbackIrqFlag_reg, irqRequest_reg,
			busClkSelOut_reg, moduleClkSelOut_reg}, 16'h000D);
		@(posedge clk_sys);
		fallbackIrqClr <= 1'b1;
		@(posedge clk_sys);
		fallbackIrqClr <= 1'b0;
		repeat (2) @(posedge clk_sys);
		#1;
		check({fallbackIrqFlag_reg, irqRequest_reg}, 16'h0000);
		// Clock found during the reset period.
		doReset(1'b1, 1'b1, 1'b1);
		waitSig(0, 1'b0, MID + 8, n);
		check({useVcoClk_reg, fallbackActiveFlag_reg}, 16'h0000);
		// Special mode: no power-up fallback, so reset stays static.
		doReset(1'b1, 1'b0, 1'b0);
		repeat (MID + 8) @(posedge clk_sys);
		#1;
		check({intReset_reg, useVcoClk_reg}, 16'h0002);
		// No synthesiser supply: static until the crystal runs.
		doReset(1'b0, 1'b1, 1'b0);
		repeat (MID + 8) @(posedge clk_sys);
		#1;
		check({intReset_reg, useVcoClk_reg, pllPowerOn_reg}, 16'h0004);
		crystalOk <= 1'b1;
		waitSig(0, 1'b0, MID + 8, n);
		check(useVcoClk_reg, 1'b0);
		// Supply returns: the fallback scenarios below need it.
		@(posedge clk_sys);
		pllSupplyPresent <= 1'b1;
		// Monitor on without fallback: STOP is a monitor failure.
		cfg(1'b1, 1'b0, 1'b1, 1'b1);
		stop();
		waitSig(3, 1'b1, 3, n);
		check(intReset_reg, 1'b1);
		waitSig(0, 1'b0, MID + 12, n);
		// No fallback, monitor off, delayed wake on the crystal.
		cfg(1'b0, 1'b0, 1'b1, 1'b1);
		wakeDelayEn <= 1'b1;
		stop();
		check({stopActive_reg, oscEnable_reg}, 16'h0002);
		@(posedge clk_sys);
		irqWake <= 1'b1;
		waitSig(1, 1'b0, MID + 12, n);
		check({n >= MID, n <= MID + 8}, 16'h0003);
		check({useVcoClk_reg, fallbackActiveFlag_reg}, 16'h0000);
		@(posedge clk_sys);
		irqWake <= 1'b0;
		// Fallback allowed, delayed wake, crystal dead.
		cfg(1'b1, 1'b0, 1'b1, 1'b0);
		crystalOk <= 1'b0;
		stop();
		repeat (2) @(posedge clk_sys);
		#1;
		check({stopActive_reg, monitorActive_reg, clkMonResetReq_reg},
			16'h0004);
		@(posedge clk_sys);
		keyWakeH <= 1'b1;
		waitSig(2, 1'b1, 3, n);
		check(monitorActive_reg, 1'b1);
		waitSig(1, 1'b0, MID + 6, n);
		check({useVcoClk_reg, fallbackActiveFlag_reg, fallbackIrqFlag_reg},
			16'h0007);
		@(posedge clk_sys);
		keyWakeH <= 1'b0;
		crystalOk <= 1'b1;
		waitSig(2, 1'b0, 2 * WRAP + 8, n);
		check({fallbackActiveFlag_reg, fallbackIrqFlag_reg}, 16'h0001);
		// Every wake source, no delay, square wave present.
		@(posedge clk_sys);
		squareWave <= 1'b1;
		wakeDelayEn <= 1'b0;
		for (int i = 0; i < 6; i++) begin
			stop();
			@(posedge clk_sys);
			setWake(i, 1'b1);
			waitSig(1, 1'b0, 3, n);
			check(fallbackActiveFlag_reg, 1'b0);
			@(posedge clk_sys);
			setWake(i, 1'b0);
			waitSig(0, 1'b0, MID + 8, n);
		end
		// Fast recovery with the crystal dead runs in fallback.
		@(posedge clk_sys);
		{squareWave, crystalOk} <= 2'b00;
		stop();
		@(posedge clk_sys);
		irqWake <= 1'b1;
		waitSig(1, 1'b0, 3, n);
		check({useVcoClk_reg, fallbackActiveFlag_reg}, 16'h0003);
		@(posedge clk_sys);
		irqWake <= 1'b0;
		// Pseudo-STOP keeps the oscillator and wakes through fallback.
		crystalOk <= 1'b1;
		waitSig(2, 1'b0, 2 * WRAP + 8, n);
		@(posedge clk_sys);
		{oscKeepStopEn, wakeDelayEn} <= 2'b11;
		stop();
		check({stopActive_reg, oscEnable_reg}, 16'h0003);
		@(posedge clk_sys);
		canWake <= 1'b1;
		waitSig(2, 1'b1, 3, n);
		waitSig(1, 1'b0, MID + 6, n);
		waitSig(2, 1'b0, 3, n);
		check(fallbackActiveFlag_reg, 1'b0);
		@(posedge clk_sys);
		canWake <= 1'b0;
		printVerdict();
	end
endmodule : lhsr_limp_home_stop_recovery_tb
